// ---- src/rms_pkg.sv ----
// Operation
// - Idle: standby when choice 0, sleep when 1
// - Start field picks low-power, receive, transmit, threshold-transmit
// - Low-power choice: off with initial mode, or idle
// - Capture chip low-power mode at sequencer start
// - Idle first-timer event goes transmit or receive
// - Transmit done goes low-power choice or receive
// - Receive exit field decodes its six exits
// - Second-timer event in receive goes low-power choice
// - Code 011 bad frame with CRC on takes the timeout path unless auto flush is set
// - Timeout exit field decodes four destinations
// - Three wait-expired events count as receive timeout
// - Packet-done exit field decodes five exits
// - First timer fires step times mult after start/second
// - Second timer fires step times mult after first
// - Timer chain independent of sequencer state
// - Stop forces sequencer off at any time
// - Idle ignores all but the first-timer event
`default_nettype none
package rms_pkg;
	localparam int CLK_MHZ = 125;
	// Timer step lengths in nanoseconds, as printed.
	localparam longint STEP1_NS = 64000;
	localparam longint STEP2_NS = 4100000;
	localparam longint STEP3_NS = 262000000;
	// Base tick is the 64 us step; longer steps are counted in base ticks.
	localparam int TICK_CYC = int'(STEP1_NS * CLK_MHZ / 1000);
	localparam int STEP2_TICKS = int'((STEP2_NS + STEP1_NS / 2) / STEP1_NS);
	localparam int STEP3_TICKS = int'((STEP3_NS + STEP1_NS / 2) / STEP1_NS);

	localparam logic [31:0] ADDR_CFG = 32'h0000_0000;
	localparam logic [31:0] ADDR_TIMER = 32'h0000_0004;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] TIMER_RESET = 32'h0000_0000;
	// Config word bit positions.
	localparam int CFG_LAUNCH = 0;
	localparam int CFG_STOP = 1;
	localparam int CFG_IDLE_PWR = 2;
	localparam int CFG_LAUNCH_EXIT = 3;
	localparam int CFG_LOW_PWR = 5;
	localparam int CFG_IDLE_EXIT = 6;
	localparam int CFG_TX_EXIT = 7;
	localparam int CFG_RX_EXIT = 8;
	localparam int CFG_TO_EXIT = 11;
	localparam int CFG_PKT_EXIT = 13;
	localparam int CFG_CRC_ON = 16;
	localparam int CFG_AUTO_FLUSH = 17;
	// Timer word bit positions.
	localparam int TMR_MULT1 = 0;
	localparam int TMR_MULT2 = 8;
	localparam int TMR_STEP1 = 16;
	localparam int TMR_STEP2 = 18;

	typedef enum logic [2:0] {
		SEQ_OFF = 3'b000,
		SEQ_IDLE = 3'b001,
		SEQ_TX = 3'b010,
		SEQ_RX = 3'b011,
		SEQ_PKT = 3'b100,
		SEQ_TXWAIT = 3'b101
	} rms_state_t;

	typedef enum logic [2:0] {
		MODE_SLEEP = 3'b000,
		MODE_STDBY = 3'b001,
		MODE_SYNTH = 3'b010,
		MODE_TX = 3'b011,
		MODE_RX = 3'b100
	} rms_mode_t;

	// Packet-engine and receiver events, one-cycle pulses or levels.
	typedef struct packed {
		logic frameTxDone;
		logic frameRxDone;
		logic checkGood;
		logic queueLevelHit;
		logic queueDrained;
		logic levelHit;
		logic patternMatch;
		logic leadInFound;
		logic levelWaitExpired;
		logic leadInWaitExpired;
		logic patternWaitExpired;
	} rms_evt_t;
endpackage : rms_pkg
`default_nettype wire

// ---- src/radio_mode_sequencer.sv ----
`default_nettype none
module radio_mode_sequencer
	import rms_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [2:0] chipMode,
	input wire rms_evt_t evt,
	output rms_mode_t modeReq,
	output logic rxRelaunch,
	output logic firstTimerIrq,
	output logic secondTimerIrq
);
	logic [31:0] cfg_q;
	logic [23:0] tmr_q;
	rms_state_t state_q;
	rms_mode_t initMode_q;
	logic ackPend;
	logic wrCfg;
	logic launch;
	logic stop;
	logic tick;
	logic [15:0] preCnt_q;
	logic [19:0] t1Cnt_q;
	logic [19:0] t2Cnt_q;
	logic t1Run_q;
	logic t2Run_q;
	logic rxTimeout;

	// Byte-lane write merge shared by both config words.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Delay in base ticks for a step code and multiplier; the longest step times 255 needs 20 bits.
	function automatic logic [19:0] delayTicks(input logic [1:0] step, input logic [7:0] mult);
		logic [19:0] unit;
		case (step)
			2'b01: unit = 20'd1;
			2'b10: unit = 20'(STEP2_TICKS);
			2'b11: unit = 20'(STEP3_TICKS);
			default: unit = 20'd0;
		endcase
		delayTicks = 20'(unit * {12'd0, mult});
	endfunction : delayTicks

	assign ackPend = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wrCfg = ackPend && wb_we_i && (wb_adr_i == ADDR_CFG);
	assign launch = wrCfg && wb_sel_i[0] && wb_dat_i[CFG_LAUNCH];
	assign stop = wrCfg && wb_sel_i[0] && wb_dat_i[CFG_STOP];
	assign rxTimeout = evt.levelWaitExpired || evt.leadInWaitExpired
		|| evt.patternWaitExpired;

	// Bus slave: one wait state, ack one cycle, unmapped reads zero.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			cfg_q <= CFG_RESET;
			tmr_q <= TIMER_RESET[23:0];
		end else begin
			wb_ack_o <= ackPend;
			if (ackPend && !wb_we_i) begin
				case (wb_adr_i)
					ADDR_CFG: wb_dat_o <= {cfg_q[31:2], 2'b00};
					ADDR_TIMER: wb_dat_o <= {8'h00, tmr_q};
					ADDR_STATUS: wb_dat_o <= {24'h0, t2Run_q, t1Run_q, initMode_q[0],
						2'b00, state_q};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
			if (wrCfg) begin
				cfg_q <= merge(cfg_q, wb_dat_i, wb_sel_i) & 32'hffff_fffc;
			end
			if (ackPend && wb_we_i && wb_adr_i == ADDR_TIMER) begin
				tmr_q <= 24'(merge({8'h00, tmr_q}, wb_dat_i, wb_sel_i));
			end
		end
	end

	// Base 64 us tick from the core clock.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			preCnt_q <= 16'h0000;
			tick <= 1'b0;
		end else if (preCnt_q == 16'(TICK_CYC - 1)) begin
			preCnt_q <= 16'h0000;
			tick <= 1'b1;
		end else begin
			preCnt_q <= 16'(preCnt_q + 16'h0001);
			tick <= 1'b0;
		end
	end

	// Chained timers; they ignore the sequencer state entirely.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			t1Run_q <= 1'b0;
			t2Run_q <= 1'b0;
			t1Cnt_q <= 20'h00000;
			t2Cnt_q <= 20'h00000;
			firstTimerIrq <= 1'b0;
			secondTimerIrq <= 1'b0;
		end else begin
			firstTimerIrq <= 1'b0;
			secondTimerIrq <= 1'b0;
			if (stop) begin
				t1Run_q <= 1'b0;
				t2Run_q <= 1'b0;
			end else if (launch || secondTimerIrq) begin
				t1Cnt_q <= delayTicks(tmr_q[TMR_STEP1 +: 2], tmr_q[TMR_MULT1 +: 8]);
				t1Run_q <= tmr_q[TMR_STEP1 +: 2] != 2'b00;
			end else if (t1Run_q && tick) begin
				if (t1Cnt_q <= 20'd1) begin
					t1Run_q <= 1'b0;
					firstTimerIrq <= 1'b1;
				end else begin
					t1Cnt_q <= 20'(t1Cnt_q - 20'd1);
				end
			end
			if (!stop && firstTimerIrq) begin
				t2Cnt_q <= delayTicks(tmr_q[TMR_STEP2 +: 2], tmr_q[TMR_MULT2 +: 8]);
				t2Run_q <= tmr_q[TMR_STEP2 +: 2] != 2'b00;
			end else if (!stop && t2Run_q && tick) begin
				if (t2Cnt_q <= 20'd1) begin
					t2Run_q <= 1'b0;
					secondTimerIrq <= 1'b1;
				end else begin
					t2Cnt_q <= 20'(t2Cnt_q - 20'd1);
				end
			end
		end
	end

	// Sequencer state and requested chip mode.
	always_ff @(posedge core_clk or posedge rst) begin
		logic [1:0] toSel;
		logic lowPwr;
		logic goTo;
		logic [31:0] cfgNow;
		if (rst) begin
			state_q <= SEQ_OFF;
			initMode_q <= MODE_STDBY;
			modeReq <= MODE_STDBY;
			rxRelaunch <= 1'b0;
		end else begin
			toSel = cfg_q[CFG_TO_EXIT +: 2];
			lowPwr = 1'b0;
			goTo = 1'b0;
			// A launch write must pick low power from the word being written, not the old one.
			cfgNow = wrCfg ? merge(cfg_q, wb_dat_i, wb_sel_i) : cfg_q;
			rxRelaunch <= 1'b0;
			// Synthesiser pass is one cycle before the receiver turns on; any exit below wins.
			if (state_q == SEQ_RX && modeReq == MODE_SYNTH) begin
				modeReq <= MODE_RX;
			end
			if (stop) begin
				state_q <= SEQ_OFF;
				modeReq <= initMode_q;
			end else begin
				case (state_q)
					SEQ_OFF: begin
						if (launch && chipMode <= 3'(MODE_STDBY)) begin
							initMode_q <= rms_mode_t'(chipMode);
							case (wb_dat_i[CFG_LAUNCH_EXIT +: 2])
								2'b00: lowPwr = 1'b1;
								2'b01: begin
									state_q <= SEQ_RX;
									modeReq <= MODE_RX;
								end
								2'b10: begin
									state_q <= SEQ_TX;
									modeReq <= MODE_TX;
								end
								default: state_q <= SEQ_TXWAIT;
							endcase
						end
					end
					SEQ_TXWAIT: begin
						if (evt.queueLevelHit) begin
							state_q <= SEQ_TX;
							modeReq <= MODE_TX;
						end
					end
					SEQ_IDLE: begin
						if (firstTimerIrq) begin
							state_q <= cfg_q[CFG_IDLE_EXIT] ? SEQ_RX : SEQ_TX;
							modeReq <= cfg_q[CFG_IDLE_EXIT] ? MODE_RX : MODE_TX;
						end else begin
							modeReq <= cfg_q[CFG_IDLE_PWR] ? MODE_SLEEP : MODE_STDBY;
						end
					end
					SEQ_TX: begin
						if (evt.frameTxDone) begin
							if (cfg_q[CFG_TX_EXIT]) begin
								state_q <= SEQ_RX;
								modeReq <= MODE_RX;
							end else begin
								lowPwr = 1'b1;
							end
						end
					end
					SEQ_RX: begin
						if (secondTimerIrq) begin
							lowPwr = 1'b1;
						end else begin
							case (cfg_q[CFG_RX_EXIT +: 3])
								3'b001: if (evt.frameRxDone) state_q <= SEQ_PKT;
								3'b010: if (evt.frameRxDone) lowPwr = 1'b1;
								3'b011: begin
									if (evt.checkGood) begin
										state_q <= SEQ_PKT;
									end else if (evt.frameRxDone && cfg_q[CFG_CRC_ON]
										&& !cfg_q[CFG_AUTO_FLUSH]) begin
										goTo = 1'b1;
									end
								end
								3'b100: if (evt.levelHit) goTo = 1'b0;
								default: ;
							endcase
							if ((cfg_q[CFG_RX_EXIT +: 3] == 3'b100 && evt.levelHit)
								|| (cfg_q[CFG_RX_EXIT +: 3] == 3'b101 && evt.patternMatch)
								|| (cfg_q[CFG_RX_EXIT +: 3] == 3'b110 && evt.leadInFound)) begin
								state_q <= SEQ_OFF;
								modeReq <= initMode_q;
							end
							if (rxTimeout || goTo) begin
								case (toSel)
									2'b00: rxRelaunch <= 1'b1;
									2'b01: begin
										state_q <= SEQ_TX;
										modeReq <= MODE_TX;
									end
									2'b10: lowPwr = 1'b1;
									default: begin
										state_q <= SEQ_OFF;
										modeReq <= initMode_q;
									end
								endcase
							end
						end
					end
					SEQ_PKT: begin
						case (cfg_q[CFG_PKT_EXIT +: 3])
							3'b000: begin
								state_q <= SEQ_OFF;
								modeReq <= initMode_q;
							end
							3'b001: begin
								if (evt.queueDrained) begin
									state_q <= SEQ_TX;
									modeReq <= MODE_TX;
								end
							end
							3'b010: lowPwr = 1'b1;
							3'b011: begin
								state_q <= SEQ_RX;
								modeReq <= MODE_SYNTH;
							end
							3'b100: begin
								state_q <= SEQ_RX;
								modeReq <= MODE_RX;
							end
							default: ;
						endcase
					end
					default: state_q <= SEQ_OFF;
				endcase
				if (lowPwr) begin
					if (cfgNow[CFG_LOW_PWR]) begin
						state_q <= SEQ_IDLE;
						modeReq <= cfgNow[CFG_IDLE_PWR] ? MODE_SLEEP : MODE_STDBY;
					end else begin
						state_q <= SEQ_OFF;
						modeReq <= initMode_q;
					end
				end
			end
		end
	end

	property p_stop_off;
		@(posedge core_clk) disable iff (rst) stop |=> state_q == SEQ_OFF;
	endproperty
	a_stop_off: assert property (p_stop_off) else $error("Stop did not turn off");

	property p_idle_exit;
		@(posedge core_clk) disable iff (rst)
			state_q == SEQ_IDLE && firstTimerIrq && !stop && cfg_q[CFG_IDLE_EXIT]
			|=> state_q == SEQ_RX;
	endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("Idle exit wrong");

	property p_idle_hold;
		@(posedge core_clk) disable iff (rst)
			state_q == SEQ_IDLE && !firstTimerIrq && !stop |=> state_q == SEQ_IDLE;
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("Idle left early");

	property p_rx_t2;
		@(posedge core_clk) disable iff (rst)
			state_q == SEQ_RX && secondTimerIrq && !stop
			|=> state_q == (cfg_q[CFG_LOW_PWR] ? SEQ_IDLE : SEQ_OFF);
	endproperty
	a_rx_t2: assert property (p_rx_t2) else $error("Second timer exit wrong");

	property p_irq_pulse;
		@(posedge core_clk) disable iff (rst) firstTimerIrq |=> !firstTimerIrq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("Timer event too long");

	property p_chain;
		@(posedge core_clk) disable iff (rst)
			firstTimerIrq && !stop && tmr_q[TMR_STEP2 +: 2] != 2'b00 |=> t2Run_q;
	endproperty
	a_chain: assert property (p_chain) else $error("Second timer not armed");

	property p_tx_done;
		@(posedge core_clk) disable iff (rst)
			state_q == SEQ_TX && evt.frameTxDone && !stop && cfg_q[CFG_TX_EXIT]
			|=> state_q == SEQ_RX && modeReq == MODE_RX;
	endproperty
	a_tx_done: assert property (p_tx_done) else $error("Transmit exit wrong");

	property p_idle_mode;
		@(posedge core_clk) disable iff (rst)
			state_q == SEQ_IDLE |-> modeReq == (cfg_q[CFG_IDLE_PWR] ? MODE_SLEEP : MODE_STDBY)
			|| $changed(cfg_q);
	endproperty
	a_idle_mode: assert property (p_idle_mode) else $error("Idle mode wrong");

	c_launch_rx: cover property (@(posedge core_clk) disable iff (rst)
		state_q == SEQ_OFF ##1 state_q == SEQ_RX);
	c_pkt: cover property (@(posedge core_clk) disable iff (rst) state_q == SEQ_PKT);
	c_relaunch: cover property (@(posedge core_clk) disable iff (rst) rxRelaunch);
endmodule : radio_mode_sequencer
`default_nettype wire

// ---- dv/test_radio_mode_sequencer.sv ----
`default_nettype none
module test_radio_mode_sequencer
	import rms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rst, wbCyc, wbStb, wbWe, wbAck, rxRelaunch, t1Irq, t2Irq;
	logic [31:0] wbAdr, wbDat, wbDatO, rd;
	logic [3:0] wbSel;
	logic [2:0] chipMode;
	rms_evt_t evt;
	rms_mode_t modeReq;
	int n_mismatch, samples_checked, cycN, nSynth;

	radio_mode_sequencer dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wbCyc),
		.wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDat),
		.wb_sel_i(wbSel), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .chipMode(chipMode),
		.evt(evt), .modeReq(modeReq), .rxRelaunch(rxRelaunch), .firstTimerIrq(t1Irq),
		.secondTimerIrq(t2Irq));

	// Free-running clock and a cycle count used to time the interval timers.
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) cycN <= cycN + 1;
	// Counts the cycles in which the synthesiser-only mode is requested.
	always @(posedge core_clk) nSynth <= nSynth + int'(modeReq == MODE_SYNTH);

	task automatic complete_run();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	task automatic ck(input logic [31:0] g, e, input string m);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, m, g, e);
		end
	endtask : ck

	// One classic bus cycle; the request stands until ack is sampled high.
	task automatic wbx(input logic w, input logic [31:0] a, d);
		int n;
		@(posedge core_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDat <= d;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		if (wbAck !== 1'b1) begin
			ck(32'h0, 32'h1, "bus ack timeout");
			complete_run();
		end
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
	endtask : wbx

	task automatic cs(input logic [2:0] s, input string m);
		wbx(1'b0, ADDR_STATUS, 32'h0);
		ck({29'h0, rd[2:0]}, {29'h0, s}, m);
	endtask : cs

	// One-cycle event pulse; reports whether a receiver restart was requested.
	task automatic ev(input logic [10:0] e, output logic r);
		@(posedge core_clk);
		evt <= rms_evt_t'(e);
		@(posedge core_clk);
		evt <= '0;
		r = 1'b0;
		repeat (3) begin
			@(posedge core_clk);
			r |= rxRelaunch;
		end
	endtask : ev

	function automatic logic [31:0] cf(input int lx, lp, ie, te, rx, to, pk, ip, crc);
		return 32'(lx << CFG_LAUNCH_EXIT | lp << CFG_LOW_PWR | ie << CFG_IDLE_EXIT
			| te << CFG_TX_EXIT | rx << CFG_RX_EXIT | to << CFG_TO_EXIT
			| pk << CFG_PKT_EXIT | ip << CFG_IDLE_PWR | crc << CFG_CRC_ON);
	endfunction : cf

	// Stops the sequencer, then launches it with the given exits.
	task automatic go(input logic [31:0] c);
		wbx(1'b1, ADDR_CFG, 32'h2);
		wbx(1'b1, ADDR_CFG, c | 32'h1);
	endtask : go

	// Waits for one timer pulse and returns the cycles since t0.
	task automatic wt(input logic sel2, input int t0, output int d);
		int n;
		n = 0;
		while ((sel2 ? t2Irq : t1Irq) !== 1'b1 && n < 3 * TICK_CYC) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 3 * TICK_CYC) begin
			ck(32'h0, 32'h1, "timer pulse timeout");
			complete_run();
		end
		d = cycN - t0;
	endtask : wt

	task automatic t_reg();
		ck(32'(modeReq), 32'(MODE_STDBY), "mode after reset");
		cs(3'h0, "state after reset");
		ck({30'h0, rd[7:6]}, 32'h0, "timers stopped after reset");
		wbx(1'b0, ADDR_CFG, 32'h0);
		ck(rd, CFG_RESET, "cfg reset");
		wbx(1'b0, ADDR_TIMER, 32'h0);
		ck(rd, TIMER_RESET, "timer reset");
		wbx(1'b1, ADDR_TIMER, 32'hfffa_5c3c);
		wbx(1'b0, ADDR_TIMER, 32'h0);
		ck(rd, 32'h00fa_5c3c, "timer readback");
		wbx(1'b1, ADDR_TIMER, 32'h0);
		wbx(1'b0, 32'h0000_0010, 32'h0);
		ck(rd, 32'h0, "unmapped read");
	endtask : t_reg

	task automatic t_start();
		logic r;
		for (int m = 0; m < 2; m++) begin
			chipMode <= 3'(m);
			go(cf(2, 0, 0, 0, 0, 0, 0, 0, 0));
			cs(3'h2, "launch to tx");
			ck(32'(modeReq), 32'(MODE_TX), "tx mode");
			ev(11'h400, r);
			cs(3'h0, "tx done to off");
			ck(32'(modeReq), 32'(m), "initial mode");
		end
		go(cf(1, 0, 0, 0, 0, 0, 0, 0, 0));
		cs(3'h3, "launch to rx");
		ck(32'(modeReq), 32'(MODE_RX), "rx mode");
		go(cf(2, 0, 0, 1, 0, 0, 0, 0, 0));
		ev(11'h400, r);
		cs(3'h3, "tx done to rx");
		go(cf(3, 0, 0, 0, 0, 0, 0, 0, 0));
		cs(3'h5, "wait for threshold");
		ev(11'h080, r);
		cs(3'h2, "threshold to tx");
		go(cf(0, 0, 0, 0, 0, 0, 0, 0, 0));
		cs(3'h0, "low power to off");
		go(cf(0, 1, 0, 0, 0, 0, 0, 0, 0));
		cs(3'h1, "low power to idle");
		ck(32'(modeReq), 32'(MODE_STDBY), "idle standby");
		chipMode <= 3'h4;
		go(cf(1, 0, 0, 0, 0, 0, 0, 0, 0));
		cs(3'h0, "launch refused outside low power");
		chipMode <= 3'h1;
	endtask : t_start

	task automatic t_rx();
		logic r;
		logic [10:0] ea[8] = '{11'h200, 11'h200, 11'h200, 11'h100, 11'h020, 11'h010,
			11'h008, 11'h200};
		logic [2:0] sa[8] = '{3'h3, 3'h4, 3'h0, 3'h4, 3'h0, 3'h0, 3'h0, 3'h3};
		for (int k = 0; k < 8; k++) begin
			// Packet-done exit waits for a drain, so the packet state stays visible.
			go(cf(1, 0, 0, 0, k, 2, 1, 0, 0));
			ev(ea[k], r);
			cs(sa[k], "rx exit code");
		end
	endtask : t_rx

	task automatic t_to();
		logic r;
		logic [10:0] ea[4] = '{11'h004, 11'h002, 11'h001, 11'h002};
		logic [2:0] sa[4] = '{3'h3, 3'h2, 3'h0, 3'h0};
		for (int k = 0; k < 4; k++) begin
			go(cf(1, 0, 0, 0, 1, k, 0, 0, 0));
			ev(ea[k], r);
			cs(sa[k], "timeout exit");
			ck(32'(r), 32'(k == 0), "receiver restart");
		end
		go(cf(1, 0, 0, 0, 3, 1, 0, 0, 1));
		ev(11'h200, r);
		cs(3'h2, "bad frame takes timeout path");
		go(cf(1, 0, 0, 0, 3, 1, 0, 0, 1) | (32'h1 << CFG_AUTO_FLUSH));
		ev(11'h200, r);
		cs(3'h3, "auto flush keeps receiving");
	endtask : t_to

	task automatic t_pkt();
		logic r;
		int s0;
		logic [2:0] sa[5] = '{3'h0, 3'h4, 3'h0, 3'h3, 3'h3};
		for (int k = 0; k < 5; k++) begin
			go(cf(1, 0, 0, 0, 1, 0, k, 0, 0));
			s0 = nSynth;
			ev(11'h200, r);
			cs(sa[k], "packet exit");
			ck(32'(nSynth - s0), 32'(k == 3), "synthesiser pass");
			if (k >= 3) ck(32'(modeReq), 32'(MODE_RX), "rx after packet");
		end
		ev(11'h040, r);
		go(cf(1, 0, 0, 0, 1, 0, 1, 0, 0));
		ev(11'h200, r);
		ev(11'h040, r);
		cs(3'h2, "drained to tx");
	endtask : t_pkt

	task automatic t_timer();
		int t0, d;
		logic r;
		wbx(1'b1, ADDR_TIMER, 32'h0005_0202);
		go(cf(0, 1, 1, 0, 0, 0, 0, 1, 0));
		t0 = cycN;
		cs(3'h1, "idle");
		ck(32'(modeReq), 32'(MODE_SLEEP), "idle sleep");
		ev(11'h7ff, r);
		cs(3'h1, "idle ignores events");
		wt(1'b0, t0, d);
		ck(32'(d >= TICK_CYC && d <= 2 * TICK_CYC + 8), 32'h1, "first delay");
		t0 = cycN;
		cs(3'h3, "first timer to rx");
		wt(1'b1, t0, d);
		ck(32'(d >= TICK_CYC && d <= 2 * TICK_CYC + 8), 32'h1, "second delay");
		t0 = cycN;
		cs(3'h1, "second timer to low power");
		wt(1'b0, t0, d);
		ck(32'(d >= TICK_CYC && d <= 2 * TICK_CYC + 8), 32'h1, "rearm delay");
		wbx(1'b1, ADDR_CFG, 32'h2);
		cs(3'h0, "stop forces off");
	endtask : t_timer

	// Reset, then each scenario in turn.
	initial begin
		rst = 1'b1;
		{wbCyc, wbStb, wbWe, cycN, nSynth, n_mismatch, samples_checked} = '0;
		{wbAdr, wbDat} = '0;
		wbSel = 4'hf;
		chipMode = 3'h1;
		evt = '0;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		t_reg();
		t_start();
		t_rx();
		t_to();
		t_pkt();
		t_timer();
		complete_run();
	end
endmodule : test_radio_mode_sequencer
`default_nettype wire
